// >>> hdl/fupg_guard.sv
// Purpose: flash user-program guard, key, launch and erase abort
// Assumes: peripheral interrupt enable/pending and mask are inputs
// Notes: flash array and byte path lie outside; this gates them
`timescale 1ns/1ps
module fupg_guard (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [fupg_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [fupg_pkg::DATA_W-1:0] writedata,
    output logic [fupg_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic periphIrqEnable,
    input wire logic periphIrqPending,
    input wire logic interruptMaskReg,
    input wire logic flashEraseFail,
    output logic cpuIrqTake,
    output logic userProgramMode,
    output logic programAllowed,
    output logic eraseBusy,
    output logic lockBusy,
    output logic hardLocked,
    output logic irq
);
    logic [fupg_pkg::KEY_W-1:0] key_q;
    logic [fupg_pkg::MODE_W-1:0] mode_q;
    logic launch_q;
    logic result_q;
    logic [fupg_pkg::IRQ_W-1:0] irqStat_q;
    logic [fupg_pkg::IRQ_W-1:0] irqMask_q;
    fupg_pkg::fupg_state_e state_q;
    logic [fupg_pkg::DATA_W-1:0] rdata_q;
    logic userMode_q;
    logic progOk_q;
    logic take_q;
    logic eraseBusy_q;
    logic lockBusy_q;
    logic locked_q;
    logic irq_q;

    logic rdLoad;
    logic wrTake;
    logic rdTake;
    logic wait_w;
    logic opDone;
    logic intReq;
    logic launchWr;
    logic startOp;
    logic refuse;
    logic abortErase;
    logic [fupg_pkg::MODE_W-1:0] newMode;
    logic [fupg_pkg::CNT_W-1:0] opTicks;

    function automatic logic isOpMode(input logic [fupg_pkg::MODE_W-1:0] m);
        return (m == fupg_pkg::MODE_SECTOR_ERASE) ||
               (m == fupg_pkg::MODE_HARD_LOCK);
    endfunction

    function automatic logic isAt(input logic [fupg_pkg::ADDR_W-1:0] a,
                                  input logic [fupg_pkg::ADDR_W-1:0] r);
        return a == r;
    endfunction

    fupg_bus_slave i_fupg_bus_slave (
        .clk(clk),
        .nrst(nrst),
        .read(read),
        .write(write),
        .waitrequest(wait_w),
        .rdLoad(rdLoad),
        .wrTake(wrTake),
        .rdTake(rdTake)
    );

    // one launch write per op; writing mode and launch together is allowed
    assign newMode = writedata[fupg_pkg::CTRL_MODE_LSB +: fupg_pkg::MODE_W];
    assign launchWr = wrTake && isAt(address, fupg_pkg::ADDR_CTRL) &&
                      writedata[fupg_pkg::CTRL_LAUNCH_BIT];
    assign startOp = launchWr && (state_q == fupg_pkg::ST_IDLE) &&
                     userMode_q && isOpMode(newMode);
    // launch with key off, bad mode or while busy is dropped
    assign refuse = launchWr && !startOp;
    assign intReq = periphIrqEnable && periphIrqPending;
    assign abortErase = (state_q == fupg_pkg::ST_ERASE) && intReq;
    assign opTicks = (newMode == fupg_pkg::MODE_SECTOR_ERASE) ?
                     fupg_pkg::ERASE_TICKS : fupg_pkg::LOCK_TICKS;

    fupg_op_timer i_fupg_op_timer (
        .clk(clk),
        .nrst(nrst),
        .start(startOp),
        .stop(abortErase),
        .ticks(opTicks),
        .done(opDone)
    );

    // key register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            key_q <= fupg_pkg::KEY_RESET;
        end else if (wrTake && isAt(address, fupg_pkg::ADDR_KEY)) begin
            key_q <= writedata[fupg_pkg::KEY_W-1:0];
        end
    end

    // mode is decoded from the key write data, so a bad write drops it on the same edge as the key
    always_ff @(posedge clk) begin
        if (!nrst) begin
            userMode_q <= 1'b0;
        end else if (wrTake && isAt(address, fupg_pkg::ADDR_KEY)) begin
            userMode_q <= writedata[fupg_pkg::KEY_W-1:0] ==
                          fupg_pkg::KEY_ENABLE;
        end
    end

    // mode field; frozen while an operation runs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_q <= fupg_pkg::MODE_RESET;
        end else if (wrTake && isAt(address, fupg_pkg::ADDR_CTRL) &&
                     state_q == fupg_pkg::ST_IDLE) begin
            mode_q <= newMode;
        end
    end

    // operation sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= fupg_pkg::ST_IDLE;
        end else begin
            case (state_q)
                fupg_pkg::ST_IDLE: begin
                    if (startOp &&
                        newMode == fupg_pkg::MODE_SECTOR_ERASE) begin
                        state_q <= fupg_pkg::ST_ERASE;
                    end else if (startOp) begin
                        state_q <= fupg_pkg::ST_LOCK;
                    end
                end
                fupg_pkg::ST_ERASE: begin
                    if (abortErase || opDone) begin
                        state_q <= fupg_pkg::ST_IDLE;
                    end
                end
                fupg_pkg::ST_LOCK: begin
                    if (opDone) begin
                        state_q <= fupg_pkg::ST_IDLE;
                    end
                end
                default: state_q <= fupg_pkg::ST_IDLE;
            endcase
        end
    end

    // launch bit reads one while busy and self-clears
    always_ff @(posedge clk) begin
        if (!nrst) begin
            launch_q <= 1'b0;
        end else if (startOp) begin
            launch_q <= 1'b1;
        end else if (opDone || abortErase) begin
            launch_q <= 1'b0;
        end
    end

    // result flag: hardware only, bus writes never reach it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            result_q <= 1'b0;
        end else if (abortErase) begin
            result_q <= 1'b1;
        end else if (opDone && state_q == fupg_pkg::ST_ERASE) begin
            result_q <= flashEraseFail;
        end
    end

    // hard lock holds until reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            locked_q <= 1'b0;
        end else if (opDone && state_q == fupg_pkg::ST_LOCK) begin
            locked_q <= 1'b1;
        end
    end

    // byte path gate; launch bit plays no part here
    always_ff @(posedge clk) begin
        if (!nrst) begin
            progOk_q <= 1'b0;
        end else begin
            progOk_q <= userMode_q && state_q == fupg_pkg::ST_IDLE &&
                        mode_q == fupg_pkg::MODE_PROGRAM;
        end
    end

    // erase overrides the cpu mask so an erase cannot starve interrupts
    always_ff @(posedge clk) begin
        if (!nrst) begin
            take_q <= 1'b0;
        end else begin
            take_q <= intReq && (interruptMaskReg ||
                      state_q == fupg_pkg::ST_ERASE);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            eraseBusy_q <= 1'b0;
            lockBusy_q <= 1'b0;
        end else begin
            eraseBusy_q <= state_q == fupg_pkg::ST_ERASE && !abortErase &&
                           !opDone;
            lockBusy_q <= state_q == fupg_pkg::ST_LOCK && !opDone;
        end
    end

    // sticky status; a new event wins over the read clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqStat_q <= fupg_pkg::IRQ_RESET;
        end else begin
            if (rdTake && isAt(address, fupg_pkg::ADDR_IRQ_STAT)) begin
                // clear only what the read reported; later events survive
                irqStat_q <= irqStat_q & ~rdata_q[fupg_pkg::IRQ_W-1:0];
            end
            if (opDone) begin
                irqStat_q[fupg_pkg::IRQ_DONE_BIT] <= 1'b1;
            end
            if (abortErase) begin
                irqStat_q[fupg_pkg::IRQ_ABORT_BIT] <= 1'b1;
            end
            if (refuse) begin
                irqStat_q[fupg_pkg::IRQ_REFUSED_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqMask_q <= fupg_pkg::IRQ_RESET;
        end else if (wrTake && isAt(address, fupg_pkg::ADDR_IRQ_MASK)) begin
            irqMask_q <= writedata[fupg_pkg::IRQ_W-1:0];
        end
    end

    // one cycle behind the status bits, to keep the output a flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irqStat_q & irqMask_q);
        end
    end

    // read data captured in the wait cycle, held through completion
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (rdLoad) begin
            rdata_q <= '0;
            case (address)
                fupg_pkg::ADDR_KEY:
                    rdata_q[fupg_pkg::KEY_W-1:0] <= key_q;
                fupg_pkg::ADDR_CTRL: begin
                    rdata_q[fupg_pkg::CTRL_MODE_LSB +: fupg_pkg::MODE_W]
                        <= mode_q;
                    rdata_q[fupg_pkg::CTRL_RESULT_BIT] <= result_q;
                    rdata_q[fupg_pkg::CTRL_LAUNCH_BIT] <= launch_q;
                end
                fupg_pkg::ADDR_IRQ_STAT:
                    rdata_q[fupg_pkg::IRQ_W-1:0] <= irqStat_q;
                fupg_pkg::ADDR_IRQ_MASK:
                    rdata_q[fupg_pkg::IRQ_W-1:0] <= irqMask_q;
                default: rdata_q <= '0;
            endcase
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_w;
    assign cpuIrqTake = take_q;
    assign userProgramMode = userMode_q;
    assign programAllowed = progOk_q;
    assign eraseBusy = eraseBusy_q;
    assign lockBusy = lockBusy_q;
    assign hardLocked = locked_q;
    assign irq = irq_q;
endmodule // fupg_guard

// >>> include/fupg_pkg.sv
// Purpose: constants for the flash user-program guard
// Assumes: 200 MHz clk, Avalon-MM word-addressed registers
// Notes: register layout and timings are chosen defaults
package fupg_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 3;
    localparam int KEY_W = 8;
    localparam int MODE_W = 4;
    localparam int IRQ_W = 3;
    localparam int CNT_W = 16;

    // word indices on the bus
    localparam logic [ADDR_W-1:0] ADDR_KEY = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h3;

    localparam logic [KEY_W-1:0] KEY_ENABLE = 8'ha5;
    localparam logic [KEY_W-1:0] KEY_RESET = 8'h00;

    // control register fields
    localparam int CTRL_LAUNCH_BIT = 0;
    localparam int CTRL_RESULT_BIT = 2;
    localparam int CTRL_MODE_LSB = 4;
    localparam logic [MODE_W-1:0] MODE_PROGRAM = 4'h5;
    localparam logic [MODE_W-1:0] MODE_HARD_LOCK = 4'h6;
    localparam logic [MODE_W-1:0] MODE_SECTOR_ERASE = 4'ha;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;

    // interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;
    localparam int IRQ_REFUSED_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // timing
    localparam int CLK_MHZ = 200;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
    localparam int ERASE_TIME_US = 20;
    localparam int LOCK_TIME_US = 10;
    localparam logic [CNT_W-1:0] ERASE_TICKS = CNT_W'(ERASE_TIME_US / TICK_US);
    localparam logic [CNT_W-1:0] LOCK_TICKS = CNT_W'(LOCK_TIME_US / TICK_US);

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_LOCK} fupg_state_e;
endpackage

// >>> hdl/fupg_bus_slave.sv
// Purpose: Avalon-MM handshake with one wait state
// Assumes: master holds request until waitrequest seen low
// Notes: waitrequest idles high; access completes on the low edge
`timescale 1ns/1ps
module fupg_bus_slave (
    input wire logic clk,
    input wire logic nrst,
    input wire logic read,
    input wire logic write,
    output logic waitrequest,
    output logic rdLoad,
    output logic wrTake,
    output logic rdTake
);
    logic wait_q;

    // high by default so an idle bus never sees a stray completion
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wait_q <= 1'b1;
        end else if ((read || write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    assign waitrequest = wait_q;
    assign rdLoad = read && wait_q;
    assign wrTake = write && !wait_q;
    assign rdTake = read && !wait_q;
endmodule // fupg_bus_slave

// >>> hdl/fupg_op_timer.sv
// Purpose: microsecond tick divider and operation countdown
// Assumes: start and stop are one-cycle pulses
// Notes: stop cancels without a done pulse
`timescale 1ns/1ps
module fupg_op_timer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic stop,
    input wire logic [fupg_pkg::CNT_W-1:0] ticks,
    output logic done
);
    localparam logic [7:0] DIV_LAST = 8'(fupg_pkg::TICK_CYCLES - 1);
    localparam logic [fupg_pkg::CNT_W-1:0] CNT_LAST = 'd1;
    logic [7:0] div_q;
    logic [fupg_pkg::CNT_W-1:0] cnt_q;
    logic run_q;
    logic tick;
    logic done_q;

    assign tick = run_q && (div_q == DIV_LAST);

    always_ff @(posedge clk) begin
        if (!nrst || start || !run_q || tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            run_q <= 1'b0;
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (stop) begin
                run_q <= 1'b0;
            end else if (start) begin
                run_q <= 1'b1;
                cnt_q <= ticks;
            end else if (tick) begin
                if (cnt_q <= CNT_LAST) begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    assign done = done_q;
endmodule // fupg_op_timer

// >>> verification/fupg_guard_chk.sv
// Purpose: port checks for the flash user-program guard
// Assumes: one clk domain, synchronous active-low nrst
// Notes: bound to fupg_guard below the module
`timescale 1ns/1ps
module fupg_guard_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [fupg_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [fupg_pkg::DATA_W-1:0] writedata,
    input wire logic waitrequest,
    input wire logic periphIrqEnable,
    input wire logic periphIrqPending,
    input wire logic cpuIrqTake,
    input wire logic userProgramMode,
    input wire logic eraseBusy,
    input wire logic lockBusy,
    input wire logic hardLocked
);
    logic keyHit;
    assign keyHit = writedata[fupg_pkg::KEY_W-1:0] == fupg_pkg::KEY_ENABLE;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence sKeyWr;
        write && !waitrequest && address == fupg_pkg::ADDR_KEY;
    endsequence
    sequence sReq;
        $rose(read || write);
    endsequence
    sequence sAbort;
        eraseBusy && periphIrqEnable && periphIrqPending;
    endsequence
    a_key_on: assert property (sKeyWr ##0 keyHit
        |-> ##[1:2] userProgramMode) else $error("key did not enable");
    a_key_off: assert property (sKeyWr ##0 !keyHit
        |-> ##[1:2] !userProgramMode) else $error("key did not disable");
    a_reset_clear: assert property ($rose(nrst) |-> !userProgramMode
        && !eraseBusy && !hardLocked && waitrequest) else $error("reset state");
    a_busy_key: assert property ($rose(eraseBusy) || $rose(lockBusy)
        |-> $past(userProgramMode)) else $error("launch without key");
    a_abort_stop: assert property (sAbort |=> !eraseBusy)
        else $error("erase not aborted");
    a_abort_take: assert property (sAbort |=> cpuIrqTake)
        else $error("interrupt not taken in erase");
    a_no_pending: assert property (!(periphIrqEnable && periphIrqPending)
        |=> !cpuIrqTake) else $error("interrupt taken without pending");
    a_wait_start: assert property (sReq |=> !waitrequest)
        else $error("request not answered");
    a_wait_one: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    a_lock_sticky: assert property (hardLocked |=> hardLocked)
        else $error("hard lock lost");
    a_one_busy: assert property (!(eraseBusy && lockBusy))
        else $error("erase and lock together");
endmodule // fupg_guard_chk

bind fupg_guard fupg_guard_chk i_fupg_guard_chk (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .waitrequest(waitrequest), .periphIrqEnable(periphIrqEnable),
    .periphIrqPending(periphIrqPending), .cpuIrqTake(cpuIrqTake),
    .userProgramMode(userProgramMode), .eraseBusy(eraseBusy),
    .lockBusy(lockBusy), .hardLocked(hardLocked));

// >>> verification/fupg_guard_test.sv
// Purpose: self-checking bench for the flash user-program guard
// Assumes: one wait state per bus access, package erase timings
// Notes: read data checked by a queue monitor, flags inline
`timescale 1ns/1ps
module fupg_guard_test;
    logic clk, nrst, read, write, waitrequest, irq;
    logic [fupg_pkg::ADDR_W-1:0] address;
    logic [fupg_pkg::DATA_W-1:0] writedata, readdata;
    logic periphIrqEnable, periphIrqPending, interruptMaskReg, flashEraseFail;
    logic cpuIrqTake, userProgramMode, programAllowed;
    logic eraseBusy, lockBusy, hardLocked;
    int fail_count, samples_checked, cycles;
    logic [31:0] rng, v;
    logic [31:0] expQ[$];
    fupg_guard i_fupg_guard (.clk(clk), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .periphIrqEnable(periphIrqEnable), .periphIrqPending(periphIrqPending),
        .interruptMaskReg(interruptMaskReg), .flashEraseFail(flashEraseFail),
        .cpuIrqTake(cpuIrqTake), .userProgramMode(userProgramMode),
        .programAllowed(programAllowed), .eraseBusy(eraseBusy),
        .lockBusy(lockBusy), .hardLocked(hardLocked), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] xorshift();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // let the edge's updates land before looking
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // reads pass the expected value in d
    task automatic bus(logic rd, logic [2:0] a, logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= rd;
        write <= !rd;
        writedata <= d;
        if (rd) expQ.push_back(d);
        do @(posedge clk); while (waitrequest);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 6000 && (eraseBusy || lockBusy); i++)
            @(posedge clk);
        tick(1);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles > 30000) begin
            fail_count++;
            give_verdict();
        end else if (nrst && read && !waitrequest) begin
            check("readdata", readdata, expQ.pop_front());
        end
    end
    initial begin
        rng = 32'h0000828d;
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        periphIrqEnable = 1'b0;
        periphIrqPending = 1'b0;
        interruptMaskReg = 1'b0;
        flashEraseFail = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        tick(1);
        bus(1, 0, 32'h0);
        check("userProgramMode", 32'(userProgramMode), 0);
        bus(0, 3, 32'h7);
        bus(0, 1, 32'ha1);
        tick(2);
        check("eraseBusy", 32'(eraseBusy), 0);
        check("irq", 32'(irq), 1);
        bus(1, 1, 32'ha0);
        bus(1, 2, 32'h4);
        tick(2);
        check("irq", 32'(irq), 0);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            interruptMaskReg <= m[0];
            periphIrqEnable <= 1'b1;
            periphIrqPending <= 1'b1;
            tick(3);
            check("cpuIrqTake", 32'(cpuIrqTake), m);
        end
        @(posedge clk);
        periphIrqEnable <= 1'b0;
        periphIrqPending <= 1'b0;
        interruptMaskReg <= 1'b0;
        $display("finished refusal test");
        for (int k = 0; k < 4; k++) begin
            bus(0, 0, 32'ha5);
            tick(3);
            check("userProgramMode", 32'(userProgramMode), 1);
            v = xorshift();
            if (k == 0) v = 32'ha4;
            if (v[7:0] == 8'ha5) v[0] = 1'b0;
            bus(0, 0, v);
            tick(3);
            check("userProgramMode", 32'(userProgramMode), 0);
        end
        bus(0, 0, 32'ha5);
        bus(1, 0, 32'ha5);
        bus(0, 1, 32'ha2);
        tick(3);
        check("eraseBusy", 32'(eraseBusy), 0);
        bus(0, 1, 32'h51);
        tick(3);
        check("programAllowed", 32'(programAllowed), 1);
        check("eraseBusy", 32'(eraseBusy), 0);
        bus(1, 1, 32'h50);
        bus(1, 2, 32'h4);
        bus(0, 0, 32'h0);
        tick(3);
        check("programAllowed", 32'(programAllowed), 0);
        bus(0, 0, 32'ha5);
        $display("finished key test");
        // first erase fails, so the later passing erase's result read sees a real flip
        @(posedge clk);
        flashEraseFail <= 1'b1;
        // result bit written as one must not stick
        bus(0, 1, 32'ha5);
        tick(3);
        check("eraseBusy", 32'(eraseBusy), 1);
        bus(0, 1, 32'h61);
        bus(1, 1, 32'ha1);
        wait_idle();
        bus(1, 1, 32'ha4);
        bus(1, 2, 32'h5);
        bus(0, 1, 32'h61);
        tick(3);
        check("lockBusy", 32'(lockBusy), 1);
        wait_idle();
        check("hardLocked", 32'(hardLocked), 1);
        bus(1, 1, 32'h64);
        bus(1, 2, 32'h1);
        @(posedge clk);
        flashEraseFail <= 1'b0;
        bus(0, 1, 32'ha1);
        tick(3);
        wait_idle();
        bus(1, 1, 32'ha0);
        bus(1, 2, 32'h1);
        $display("finished erase test");
        @(posedge clk);
        flashEraseFail <= 1'b0;
        bus(0, 3, 32'h0);
        bus(0, 1, 32'ha1);
        tick(20);
        @(posedge clk);
        periphIrqEnable <= 1'b1;
        periphIrqPending <= 1'b1;
        tick(1);
        check("eraseBusy", 32'(eraseBusy), 0);
        check("cpuIrqTake", 32'(cpuIrqTake), 1);
        check("irq", 32'(irq), 0);
        @(posedge clk);
        periphIrqEnable <= 1'b0;
        periphIrqPending <= 1'b0;
        bus(1, 1, 32'ha4);
        bus(1, 2, 32'h2);
        $display("finished abort test");
        @(posedge clk);
        nrst <= 1'b0;
        tick(2);
        @(posedge clk);
        nrst <= 1'b1;
        tick(1);
        check("hardLocked", 32'(hardLocked), 0);
        bus(1, 0, 32'h0);
        bus(0, 5, 32'ha5);
        tick(3);
        check("userProgramMode", 32'(userProgramMode), 0);
        bus(1, 5, 32'h0);
        $display("finished reset test");
        give_verdict();
    end
endmodule // fupg_guard_test
